// *** verilog/abd_consts.svh ***
// constants of the auto-baud rate detector: offsets, fields, resets, divisors
// Contract
// - receive line times the counter over 55h
// - enable starts; receiver held idle meanwhile
// - count from first rise after start bit
// - fifth rise: keep count, clear enable, flag
// - receive data read clears receive flag
// - both divisor bytes form one 16-bit counter
// - counter runs at one eighth base rate
// - speed bits pick /512, /128 or /32
// - counter starts at one; software subtracts one
// - with wake enabled, measure character after break
// - overflow sets flag, counting continues to edge five
// - overflow flag stays while enable still set
// - divisor write resets the running baud timer
`ifndef ABD_CONSTS_SVH
`define ABD_CONSTS_SVH

// register byte offsets
`define ABD_OFS_CTRL 8'h00
`define ABD_OFS_DIV_LO 8'h04
`define ABD_OFS_DIV_HI 8'h08
`define ABD_OFS_RX_DATA 8'h0c
`define ABD_OFS_IRQ_STS 8'h10
`define ABD_OFS_IRQ_MSK 8'h14

// control register field positions
`define ABD_CTRL_EN 0
`define ABD_CTRL_WAKE 1
`define ABD_CTRL_WIDE 2
`define ABD_CTRL_HSPD 3
`define ABD_CTRL_RIF 5
`define ABD_CTRL_IDLE 6
`define ABD_CTRL_OVF 7

// interrupt status bit positions
`define ABD_IRQ_DONE 0
`define ABD_IRQ_OVF 1
`define ABD_IRQ_WAKE 2

// reset values
`define ABD_RST_DIV 16'h0000
`define ABD_RST_IRQ 3'h0
`define ABD_RST_LINE 1'b1

// auto-baud counter clock divisors, system clock cycles per tick
`define ABD_DIV_SLOW 10'h200
`define ABD_DIV_MID 10'h080
`define ABD_DIV_FAST 10'h020
// base clock is the auto-baud clock times eight
`define ABD_BASE_SHIFT 3

// counter start value and the rise that ends the measurement
`define ABD_CNT_START 16'h0001
`define ABD_LAST_RISE 3'h5

`endif

// *** verilog/abd_pkg.sv ***
// types shared by the auto-baud rate detector
`default_nettype none
package abd_pkg;

  // measurement sequencer, gray along idle, start, count
  typedef enum logic [2:0] {
    ABD_ST_IDLE = 3'h0,
    ABD_ST_START = 3'h1,
    ABD_ST_COUNT = 3'h3,
    ABD_ST_WAKE = 3'h4,
    ABD_ST_BRK_END = 3'h5
  } abd_state_t;

  // software control fields
  typedef struct packed {
    logic high_speed_select;
    logic wide_divisor_select;
    logic wake_on_break_enable;
    logic auto_baud_enable;
  } abd_ctrl_t;

  // captured ahb address phase
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic valid;
  } abd_aphase_t;

endpackage : abd_pkg
`default_nettype wire

// *** verilog/abd_rx_sync.sv ***
// receive line synchroniser with agreement filter and edge pulses
`include "abd_consts.svh"
`default_nettype none
module abd_rx_sync (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // asynchronous line
  input wire logic line_i,
  // filtered level and edges
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic s1_r; // first stage, read only by s2
  logic s2_r;
  logic s3_r;
  logic level_r; // level once s2 and s3 agree
  logic agree;

  // change only counts when the last two stages match
  assign agree = (s2_r == s3_r);

  // three-stage chain, idle line is high
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      s1_r <= `ABD_RST_LINE;
      s2_r <= `ABD_RST_LINE;
      s3_r <= `ABD_RST_LINE;
      level_r <= `ABD_RST_LINE;
    end else begin
      s1_r <= line_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        level_r <= s3_r;
      end
    end
  end

  // edges are a change of the filtered level
  assign level_o = level_r;
  assign rise_o = agree && s3_r && !level_r;
  assign fall_o = agree && !s3_r && level_r;

endmodule : abd_rx_sync
`default_nettype wire

// *** verilog/abd_presc.sv ***
// prescaler giving auto-baud ticks and base-clock ticks
`include "abd_consts.svh"
`default_nettype none
module abd_presc #(
  parameter int W = 10
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // restart phase
  input wire logic clr_i,
  // speed bits {wide, high}
  input wire logic [1:0] sel_i,
  // tick pulses
  output logic abd_tick_o,
  output logic base_tick_o
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;
  logic [W-1:0] div; // auto-baud divisor
  logic [W-1:0] base_mask; // base period minus one

  // both clear slow, one set mid, both set fast
  assign div = (sel_i == 2'b00) ? W'(`ABD_DIV_SLOW) :
               (sel_i == 2'b11) ? W'(`ABD_DIV_FAST) : W'(`ABD_DIV_MID);
  // base clock is eight times faster than the auto-baud clock
  assign base_mask = (div >> `ABD_BASE_SHIFT) - W'(1);
  assign abd_tick_o = (cnt_r == div - W'(1));
  assign base_tick_o = ((cnt_r & base_mask) == base_mask);
  assign cnt_nxt = abd_tick_o ? '0 : cnt_r + W'(1);

  // free counter, cleared to align the first tick with a start event
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i || clr_i) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

endmodule : abd_presc
`default_nettype wire

// *** verilog/abd_detector.sv ***
// auto-baud rate detector with ahb-lite registers and baud timer
`include "abd_consts.svh"
`default_nettype none
module abd_detector (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // ahb-lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // serial line
  input wire logic receive_line_i,
  // normal receiver of the port
  input wire logic rx_idle_i,
  output logic rx_hold_idle_o,
  output logic baud_tick_o,
  output logic [15:0] divisor_o,
  // interrupt
  output logic irq_o
);

  // ---------------- state ----------------
  abd_pkg::abd_ctrl_t ctrl_r; // software control bits
  abd_pkg::abd_state_t state_r;
  abd_pkg::abd_state_t state_nxt;
  abd_pkg::abd_aphase_t aph_r; // pending data phase
  logic [15:0] div_r; // divisor pair, also the measuring counter
  logic [15:0] div_nxt;
  logic [2:0] rise_cnt_r; // rises seen in this measurement
  logic [2:0] rise_cnt_nxt;
  logic ovf_r; // auto_baud_overflow_flag
  logic ovf_nxt;
  logic rif_r; // receive_interrupt_flag
  logic rif_nxt;
  logic [2:0] irq_sts_r;
  logic [2:0] irq_msk_r;
  logic [15:0] btmr_r; // running baud timer
  logic [15:0] btmr_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  // ---------------- line and prescaler ----------------
  logic line_lvl;
  logic line_rise;
  logic line_fall;
  logic abd_tick;
  logic base_tick;
  logic presc_clr;

  abd_rx_sync u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .line_i(receive_line_i),
    .level_o(line_lvl),
    .rise_o(line_rise),
    .fall_o(line_fall)
  );

  abd_presc #(
    .W(10)
  ) u_presc (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .clr_i(presc_clr),
    .sel_i({ctrl_r.wide_divisor_select, ctrl_r.high_speed_select}),
    .abd_tick_o(abd_tick),
    .base_tick_o(base_tick)
  );

  // ---------------- bus decode ----------------
  logic aph_take; // address phase accepted
  logic wr_en;
  logic wr_ctrl;
  logic wr_dlo;
  logic wr_dhi;
  logic wr_ists;
  logic wr_imsk;
  logic rd_rxd; // read of receive data register
  logic [7:0] aofs;

  // zero-wait slave, always okay
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign aofs = haddr_i[7:0];
  assign aph_take = hsel_i && hready_i && htrans_i[1];
  assign wr_en = aph_r.valid && aph_r.write;
  assign wr_ctrl = wr_en && (aph_r.addr == `ABD_OFS_CTRL);
  assign wr_dlo = wr_en && (aph_r.addr == `ABD_OFS_DIV_LO);
  assign wr_dhi = wr_en && (aph_r.addr == `ABD_OFS_DIV_HI);
  assign wr_ists = wr_en && (aph_r.addr == `ABD_OFS_IRQ_STS);
  assign wr_imsk = wr_en && (aph_r.addr == `ABD_OFS_IRQ_MSK);
  // side effect taken at the address phase, so the read data stays coherent
  assign rd_rxd = aph_take && !hwrite_i && (aofs == `ABD_OFS_RX_DATA);

  // ---------------- sequencer events ----------------
  logic measuring;
  logic first_rise;
  logic fifth_rise;
  logic done_ev;
  logic ovf_ev;
  logic wake_ev;
  logic brk_end_ev;
  logic sw_abort;

  assign measuring = (state_r == abd_pkg::ABD_ST_COUNT);
  assign first_rise = (state_r == abd_pkg::ABD_ST_START) && line_rise && !line_lvl;
  assign fifth_rise = measuring && line_rise
                      && (rise_cnt_r == `ABD_LAST_RISE - 3'h1);
  assign done_ev = fifth_rise;
  // wrap of the full 16-bit pair, before the fifth rise
  assign ovf_ev = measuring && abd_tick && !fifth_rise && (div_r == 16'hffff);
  assign wake_ev = (state_r == abd_pkg::ABD_ST_WAKE) && line_fall;
  assign brk_end_ev = (state_r == abd_pkg::ABD_ST_BRK_END) && line_rise;
  assign sw_abort = (state_r != abd_pkg::ABD_ST_IDLE) && !ctrl_r.auto_baud_enable;
  // restart prescaler phase when counting begins
  assign presc_clr = first_rise;

  // next state of the measurement sequencer
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      abd_pkg::ABD_ST_IDLE: begin
        if (ctrl_r.auto_baud_enable) begin
          // wake enabled: skip the break, measure the next character
          state_nxt = ctrl_r.wake_on_break_enable ? abd_pkg::ABD_ST_WAKE
                                                  : abd_pkg::ABD_ST_START;
        end
      end
      abd_pkg::ABD_ST_WAKE: begin
        if (wake_ev) begin
          state_nxt = abd_pkg::ABD_ST_BRK_END;
        end
      end
      abd_pkg::ABD_ST_BRK_END: begin
        if (brk_end_ev) begin
          state_nxt = abd_pkg::ABD_ST_START;
        end
      end
      abd_pkg::ABD_ST_START: begin
        // start bit low, then its first rise opens the count
        if (first_rise) begin
          state_nxt = abd_pkg::ABD_ST_COUNT;
        end
      end
      abd_pkg::ABD_ST_COUNT: begin
        if (done_ev) begin
          state_nxt = abd_pkg::ABD_ST_IDLE;
        end
      end
      default: begin
        state_nxt = abd_pkg::ABD_ST_IDLE;
      end
    endcase
    if (sw_abort) begin
      state_nxt = abd_pkg::ABD_ST_IDLE;
    end
  end

  // divisor pair: software bytes, or one 16-bit counter while measuring
  always_comb begin
    div_nxt = div_r;
    rise_cnt_nxt = rise_cnt_r;
    if (first_rise) begin
      div_nxt = `ABD_CNT_START;
      rise_cnt_nxt = 3'h1;
    end else if (measuring) begin
      if (line_rise) begin
        rise_cnt_nxt = rise_cnt_r + 3'h1;
      end
      // fifth rise freezes the count, the sum of eight bit times
      if (abd_tick && !fifth_rise) begin
        div_nxt = div_r + 16'h0001;
      end
    end else begin
      // software may only rewrite the pair outside a measurement
      if (wr_dlo) begin
        div_nxt[7:0] = hwdata_i[7:0];
      end
      if (wr_dhi) begin
        div_nxt[15:8] = hwdata_i[7:0];
      end
    end
  end

  // overflow flag: set wins; a clear only counts once enable is off
  always_comb begin
    ovf_nxt = ovf_r;
    if (wr_ctrl && !hwdata_i[`ABD_CTRL_OVF] && !ctrl_r.auto_baud_enable) begin
      ovf_nxt = 1'b0;
    end
    if (ovf_ev) begin
      ovf_nxt = 1'b1;
    end
  end

  // receive flag: set by completion or wake, cleared by data read
  always_comb begin
    rif_nxt = rif_r;
    if (rd_rxd) begin
      rif_nxt = 1'b0;
    end
    if (done_ev || wake_ev) begin
      rif_nxt = 1'b1;
    end
  end

  // control bits and sequencer registers
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      ctrl_r <= '0;
      state_r <= abd_pkg::ABD_ST_IDLE;
      rise_cnt_r <= 3'h0;
      div_r <= `ABD_RST_DIV;
      ovf_r <= 1'b0;
      rif_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rise_cnt_r <= rise_cnt_nxt;
      div_r <= div_nxt;
      ovf_r <= ovf_nxt;
      rif_r <= rif_nxt;
      if (wr_ctrl) begin
        ctrl_r <= hwdata_i[3:0];
      end
      // hardware clears win over a same-cycle software write
      if (done_ev) begin
        ctrl_r.auto_baud_enable <= 1'b0;
      end
      if (brk_end_ev) begin
        ctrl_r.wake_on_break_enable <= 1'b0;
      end
    end
  end

  // ---------------- baud timer ----------------
  logic [15:0] eff_div; // 8-bit mode uses the low byte only
  logic btmr_zero;

  assign eff_div = ctrl_r.wide_divisor_select ? div_r : {8'h00, div_r[7:0]};
  assign btmr_zero = (btmr_r == 16'h0000);

  // reload on zero, restart on any divisor write
  always_comb begin
    btmr_nxt = btmr_r;
    if (wr_dlo || wr_dhi || ctrl_r.auto_baud_enable) begin
      btmr_nxt = 16'h0000;
    end else if (base_tick) begin
      btmr_nxt = btmr_zero ? eff_div : btmr_r - 16'h0001;
    end
  end

  // timer and its tick output
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      btmr_r <= 16'h0000;
      baud_tick_o <= 1'b0;
    end else begin
      btmr_r <= btmr_nxt;
      baud_tick_o <= base_tick && btmr_zero && !ctrl_r.auto_baud_enable
                     && !wr_dlo && !wr_dhi;
    end
  end

  // ---------------- interrupts ----------------
  logic [2:0] irq_ev;
  logic [2:0] irq_sts_nxt;

  assign irq_ev = {wake_ev, ovf_ev, done_ev};
  // write-one-to-clear, an event in the same cycle wins
  assign irq_sts_nxt = (irq_sts_r & ~(wr_ists ? hwdata_i[2:0] : 3'h0)) | irq_ev;

  // status and mask
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_sts_r <= `ABD_RST_IRQ;
      irq_msk_r <= `ABD_RST_IRQ;
      irq_o <= 1'b0;
    end else begin
      irq_sts_r <= irq_sts_nxt;
      irq_o <= |(irq_sts_nxt & (wr_imsk ? hwdata_i[2:0] : irq_msk_r));
      if (wr_imsk) begin
        irq_msk_r <= hwdata_i[2:0];
      end
    end
  end

  // ---------------- read path ----------------
  logic idle_sts; // receiver_idle_status
  logic [31:0] ctrl_rd;

  // the receiver is held idle for the whole sequence
  assign rx_hold_idle_o = ctrl_r.auto_baud_enable;
  assign idle_sts = ctrl_r.auto_baud_enable ? 1'b1 : rx_idle_i;
  assign ctrl_rd = {24'h000000, ovf_r, idle_sts, rif_r, 1'b0, ctrl_r};
  assign divisor_o = div_r;

  // read mux, unmapped offsets read zero
  always_comb begin
    rdata_nxt = 32'h00000000;
    case (aofs)
      `ABD_OFS_CTRL: rdata_nxt = ctrl_rd;
      `ABD_OFS_DIV_LO: rdata_nxt = {24'h000000, div_r[7:0]};
      `ABD_OFS_DIV_HI: rdata_nxt = {24'h000000, div_r[15:8]};
      `ABD_OFS_IRQ_STS: rdata_nxt = {29'h00000000, irq_sts_r};
      `ABD_OFS_IRQ_MSK: rdata_nxt = {29'h00000000, irq_msk_r};
      default: rdata_nxt = 32'h00000000; // receive data reads as zero
    endcase
  end

  // address phase capture and registered read data
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      aph_r <= '0;
      rdata_r <= 32'h00000000;
    end else begin
      if (hready_i) begin
        aph_r <= '{addr: aofs, write: hwrite_i, valid: aph_take};
      end
      if (aph_take && !hwrite_i) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  assign hrdata_o = rdata_r;

endmodule : abd_detector
`default_nettype wire

// *** verification/abd_detector_monitor.sv ***
// port assertions for the auto-baud rate detector
`include "abd_consts.svh"
`default_nettype none
module abd_detector_monitor (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // bus side
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  // receiver side
  input wire logic rx_hold_idle_o,
  input wire logic baud_tick_o,
  input wire logic [15:0] divisor_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // write data phase flags
  logic ctl_dp_r;
  logic div_dp_r;
  wire logic wr_take = hsel_i & hready_i & htrans_i[1] & hwrite_i;
  wire logic div_hit = haddr_i[7:0] == `ABD_OFS_DIV_LO || haddr_i[7:0] == `ABD_OFS_DIV_HI;
  // enable bit written in this data phase
  wire logic en_wr = ctl_dp_r & hwdata_i[`ABD_CTRL_EN];

  // remember which register the data phase belongs to
  always_ff @(posedge clk_sys_i) begin
    ctl_dp_r <= rst_n_i & wr_take & (haddr_i[7:0] == `ABD_OFS_CTRL);
    div_dp_r <= rst_n_i & wr_take & div_hit;
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  bus_okay_a: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready or not okay");
  reset_vals_a: assert property ($rose(rst_n_i) |-> divisor_o == 16'h0000 && !irq_o)
    else $error("outputs not at reset values");
  hold_start_a: assert property ($rose(rx_hold_idle_o) |-> $past(en_wr))
    else $error("receiver held idle without enable write");
  hold_tick_a: assert property (rx_hold_idle_o && $past(rx_hold_idle_o) |-> !baud_tick_o)
    else $error("baud tick during measurement");
  div_change_a: assert property ($changed(divisor_o) |-> $past(rx_hold_idle_o) || $past(div_dp_r))
    else $error("divisor changed without cause");
  count_step_a: assert property (rx_hold_idle_o && $past(rx_hold_idle_o) && $changed(divisor_o)
    |-> divisor_o == $past(divisor_o) + 16'h0001 || divisor_o == 16'h0001)
    else $error("counter did not step by one");
  count_pace_a: assert property (rx_hold_idle_o && $changed(divisor_o) |=> $stable(divisor_o) [*8])
    else $error("counter ticks too fast");
  done_freeze_a: assert property ($fell(rx_hold_idle_o) |=> $stable(divisor_o) [*4])
    else $error("count not frozen at end");
  tick_pulse_a: assert property (baud_tick_o |=> !baud_tick_o)
    else $error("baud tick longer than a cycle");
  timer_restart_a: assert property (div_dp_r |=> !baud_tick_o [*2])
    else $error("baud timer not restarted by write");
endmodule : abd_detector_monitor

bind abd_detector abd_detector_monitor u_mon (.clk_sys_i, .rst_n_i, .hsel_i, .haddr_i,
  .htrans_i, .hwrite_i, .hwdata_i, .hready_i, .hreadyout_o, .hresp_o, .rx_hold_idle_o,
  .baud_tick_o, .divisor_o, .irq_o);
`default_nettype wire

// *** verification/abd_uart_tx.sv ***
// remote transmitter sending a break and the sync character
`default_nettype none
module abd_uart_tx (
  // clock
  input wire logic clk_sys_i,
  // command
  input wire logic go_i,
  input wire logic brk_i,
  input wire logic [15:0] bit_len_i,
  // line and status
  output logic line_o,
  output logic busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // sync character, sent lsb first
  logic [7:0] sync_char = 8'h55;

  // hold one level for n cycles
  task automatic put(input logic v, input int n);
    line_o <= v;
    repeat (n) @(posedge clk_sys_i);
  endtask : put

  // one frame per go pulse; line idles high
  initial begin
    line_o = 1'b1;
    busy_o = 1'b0;
    forever begin
      @(posedge clk_sys_i);
      if (go_i) begin
        busy_o <= 1'b1;
        // all-zero break and a gap before the character
        if (brk_i) begin
          put(1'b0, 12 * bit_len_i);
          put(1'b1, 2 * bit_len_i);
        end
        put(1'b0, bit_len_i);
        for (int i = 0; i < 8; i++) begin
          put(sync_char[i], bit_len_i);
        end
        // stop bit plus idle time
        put(1'b1, 2 * bit_len_i);
        busy_o <= 1'b0;
      end
    end
  end
endmodule : abd_uart_tx
`default_nettype wire

// *** verification/tb_auto_baud_rate_detector.sv ***
// self-checking bench of the auto-baud rate detector
`include "abd_consts.svh"
`default_nettype none
module tb_auto_baud_rate_detector;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic go = 1'b0;
  logic brk = 1'b0;
  logic [15:0] bit_len = 16'h0052;
  // port receiver reports busy, so an idle reading must come from the hold
  logic rx_idle = 1'b0;
  // observed
  wire logic [31:0] hrdata;
  wire logic hready;
  wire logic hold;
  wire logic tick;
  wire logic [15:0] divisor;
  wire logic irq;
  wire logic line;
  wire logic busy;
  logic [31:0] rdat;
  int n_fail = 0;
  int comparisons = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  abd_detector DUT (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
    .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
    .hresp_o(), .receive_line_i(line), .rx_idle_i(rx_idle), .rx_hold_idle_o(hold),
    .baud_tick_o(tick), .divisor_o(divisor), .irq_o(irq));

  abd_uart_tx u_tx (.clk_sys_i(clk_sys_i), .go_i(go), .brk_i(brk), .bit_len_i(bit_len),
    .line_o(line), .busy_o(busy));

  // verdict and end of run
  task automatic finish_test;
    if (n_fail == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test

  // a wait that ran out counts as a mismatch
  task automatic give_up;
    n_fail++;
    finish_test();
  endtask : give_up

  // four-state compare, counted
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : step

  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (hready !== 1'b1 && n < 16);
    if (hready !== 1'b1) give_up();
  endtask : wait_rdy

  // one single word transfer; read data lands in rdat
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy();
    rdat = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask : rd

  // arm the detector, then let the far side send a whole frame
  task automatic measure(input logic [7:0] ctl, input logic b, input logic [15:0] t);
    int n;
    n = 0;
    bit_len <= t;
    wr(`ABD_OFS_CTRL, {24'h0, ctl});
    step(1);
    chk(32'(hold), 32'h1);
    brk <= b;
    go <= 1'b1;
    @(posedge clk_sys_i);
    go <= 1'b0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (busy !== 1'b0 && n < 40000);
    if (busy !== 1'b0) give_up();
  endtask : measure

  // reset values and an unmapped word
  task automatic t_reset;
    chk(32'(divisor), 32'h0);
    rd(`ABD_OFS_DIV_LO);
    chk(rdat, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd(8'h20);
    chk(rdat, 32'h0);
    rd(`ABD_OFS_IRQ_MSK);
    chk(rdat, 32'h0);
  endtask : t_reset

  // divisor pair written, read back, timer paced by it
  task automatic t_div;
    int ticks;
    ticks = 0;
    wr(`ABD_OFS_DIV_HI, 32'ha5);
    wr(`ABD_OFS_DIV_LO, 32'h03);
    step(1);
    chk(32'(divisor), 32'ha503);
    wr(`ABD_OFS_DIV_HI, 32'h00);
    wr(`ABD_OFS_CTRL, 32'h0c);
    rd(`ABD_OFS_DIV_LO);
    chk(rdat, 32'h03);
    // four base ticks of four cycles per baud tick
    repeat (160) begin
      @(posedge clk_sys_i);
      ticks += int'(tick === 1'b1);
    end
    chk(32'(ticks >= 9 && ticks <= 11), 32'h1);
    // 8-bit mode: high byte ignored, four base ticks of sixteen cycles
    wr(`ABD_OFS_CTRL, 32'h08);
    wr(`ABD_OFS_DIV_HI, 32'ha5);
    ticks = 0;
    repeat (320) begin
      @(posedge clk_sys_i);
      ticks += int'(tick === 1'b1);
    end
    chk(32'(ticks >= 4 && ticks <= 6), 32'h1);
  endtask : t_div

  // every speed code; bit times sit half a tick off any boundary
  task automatic t_speeds;
    logic [15:0] len [4] = '{16'd224, 16'd88, 16'd88, 16'd82};
    logic [15:0] cnt [4] = '{16'd4, 16'd6, 16'd6, 16'd21};
    wr(`ABD_OFS_IRQ_MSK, 32'h1);
    for (int s = 0; s < 4; s++) begin
      measure({4'h0, s[0], s[1], 2'b01}, 1'b0, len[s]);
      chk(32'(divisor), 32'(cnt[s]));
      rd(`ABD_OFS_DIV_HI);
      chk(rdat, 32'h0);
      rd(`ABD_OFS_CTRL);
      chk(32'({rdat[5], rdat[0]}), 32'h2);
      chk(32'(irq), 32'h1);
      rd(`ABD_OFS_RX_DATA);
      rd(`ABD_OFS_CTRL);
      chk(32'(rdat[5]), 32'h0);
      wr(`ABD_OFS_IRQ_STS, 32'h1);
      step(2);
      chk(32'(irq), 32'h0);
    end
  endtask : t_speeds

  // masked event stays silent until unmasked
  task automatic t_mask;
    wr(`ABD_OFS_IRQ_MSK, 32'h0);
    measure(8'h0d, 1'b0, 16'd82);
    chk(32'(irq), 32'h0);
    rd(`ABD_OFS_IRQ_STS);
    chk(rdat, 32'h1);
    wr(`ABD_OFS_IRQ_MSK, 32'h1);
    step(2);
    chk(32'(irq), 32'h1);
    wr(`ABD_OFS_IRQ_STS, 32'h1);
    rd(`ABD_OFS_IRQ_STS);
    chk(rdat, 32'h0);
    rd(`ABD_OFS_RX_DATA);
  endtask : t_mask

  // break first, so the count must come from the character after it
  task automatic t_wake;
    wr(`ABD_OFS_IRQ_MSK, 32'h0);
    measure(8'h0f, 1'b1, 16'd82);
    chk(32'(divisor), 32'd21);
    rd(`ABD_OFS_IRQ_STS);
    chk(rdat, 32'h5);
    rd(`ABD_OFS_CTRL);
    chk(32'(rdat[1]), 32'h0);
    wr(`ABD_OFS_IRQ_STS, 32'h7);
    rd(`ABD_OFS_RX_DATA);
  endtask : t_wake

  // software gives up before any edge arrives
  task automatic t_abort;
    wr(`ABD_OFS_CTRL, 32'h1);
    step(1);
    chk(32'(hold), 32'h1);
    // idle status reads set while the receiver is held
    rd(`ABD_OFS_CTRL);
    chk(32'(rdat[6]), 32'h1);
    wr(`ABD_OFS_CTRL, 32'h0);
    wr(`ABD_OFS_CTRL, 32'h0);
    step(1);
    chk(32'(hold), 32'h0);
    // released: idle status follows the busy receiver again
    rd(`ABD_OFS_CTRL);
    chk(32'(rdat[6]), 32'h0);
    rd(`ABD_OFS_IRQ_STS);
    chk(rdat, 32'h0);
  endtask : t_abort

  // reset for twenty cycles, then every scenario in turn
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_div();
    t_speeds();
    t_mask();
    t_wake();
    t_abort();
    finish_test();
  end
endmodule : tb_auto_baud_rate_detector
`default_nettype wire
